// ==== hdl/can_buf_map.svh ====
// register offsets, field positions and sizes of the message buffer block
`ifndef CAN_BUF_MAP_SVH
`define CAN_BUF_MAP_SVH

`define CB_ADDR_W        12
`define CB_FRAME_BYTES   13
`define CB_TX_BUFS       3
`define CB_LOCAL_PRIORITY_FIELD_IDX      4'hD

// control and flag registers (byte addresses)
`define CB_CTRL          12'h000
`define CB_RXFLAG        12'h004
`define CB_RXIEN         12'h008
`define CB_TXFLAG        12'h00C
`define CB_TXCTRL        12'h010
`define CB_ABTACK        12'h014

// buffer windows: one byte per word, window index in paddr[11:6]
`define CB_RXWIN         6'h01
`define CB_TXWIN0        6'h02

// field positions
`define CB_CTRL_LOOP     0
`define CB_CTRL_OSC      1
`define CB_RX_FULL       0
`define CB_RX_OVR        1
`define CB_TXIE_LSB      4

// reset values
`define CB_CTRL_RST      2'h0
`define CB_TXE_RST       3'h7
`define CB_LOCAL_PRIORITY_FIELD_RST      8'h00

`endif

// ==== hdl/can_buf_pkg.sv ====
// types shared by the message buffer block
package can_buf_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] byteidx_t;
    typedef logic [1:0] bufidx_t;
    typedef logic [2:0] bufmask_t;
    typedef logic [11:0] addr_t;
endpackage : can_buf_pkg

// ==== hdl/can_message_buffer_manager.sv ====
// receive ping-pong buffers, transmit buffers and their APB registers
//
// Functional notes
// - transmit pin low dominant, high recessive
// - standard, extended, remote frames, 0-8 data
// - module clock source selectable bus or oscillator
// - two-stage receive FIFO, only foreground visible
// - each receive buffer holds thirteen bytes
// - receive-full set when foreground holds accepted frame
// - accepted frame copied only if receive-full clear
// - background overwritten regardless of filter result; code skips the write while the background holds a frame
// - own frames stay background, no copy, no interrupt
// - loop-back treats own frames like others
// - lost arbitration turns controller into receiver
// - both full plus accepted frame gives overrun
// - transmit works while receive buffers full
// - three thirteen-byte transmit buffers with priority
// - sent frame sets empty flag, transmit interrupt
// - smallest priority value pending is sent first
// - selection repeated at every arbitration, after errors
// - abort granted only if frame not transmitting
// - abort acknowledge one if aborted, zero sent
// - flags cleared by writing one
// - flag stays set while its condition holds
`timescale 1ns/1ps
`default_nettype none
`include "can_buf_map.svh"

module can_message_buffer_manager
    import can_buf_pkg::*;
#(
    parameter int FRAME_BYTES = `CB_FRAME_BYTES
)(
    input  wire logic              core_clk,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire can_buf_pkg::addr_t paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic              pready,
    output var  logic [31:0]       prdata,
    output var  logic              pslverr,
    // can pins
    input  wire logic              bus_receive_pin,
    output var  logic              bus_transmit_pin,
    // protocol engine side
    output var  logic              rxPinLevel,
    input  wire logic              engTxBit,
    input  wire logic              rxByteValid,
    input  wire can_buf_pkg::byteidx_t rxByteIdx,
    input  wire can_buf_pkg::byte_t rxByteData,
    input  wire logic              rxFrameOk,
    input  wire logic              rxAccept,
    input  wire logic              ownFrame,
    input  wire logic              arbStart,
    input  wire logic              arbLost,
    input  wire logic              txDone,
    input  wire logic              txError,
    input  wire can_buf_pkg::byteidx_t txRdIdx,
    output var  can_buf_pkg::byte_t txRdData,
    output var  logic              txValid,
    output var  can_buf_pkg::bufidx_t txBufSel,
    output var  logic              loopBack,
    output var  logic              clkSelOsc,
    output var  logic              rxIrq,
    output var  logic              errIrq,
    output var  logic              txIrq
);
    import can_buf_pkg::*;

    // elaboration check: byte index decode assumes a thirteen-byte image
    if (FRAME_BYTES != `CB_FRAME_BYTES)
    begin : g_bad_frame
        $error("frame image must be thirteen bytes");
    end

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    byte_t    background_receive_buffer[FRAME_BYTES];
    byte_t    foreground_receive_buffer[FRAME_BYTES];
    byte_t    txMem[`CB_TX_BUFS][FRAME_BYTES];
    byte_t    local_priority_field_q[`CB_TX_BUFS];

    logic [1:0] ctrl_q;
    logic     rxFull_q;
    logic     bgFull_q;
    logic     ovr_q;
    logic [1:0] rxIen_q;
    bufmask_t txEmpty_q;
    bufmask_t abtReq_q;
    bufmask_t abtAck_q;
    bufmask_t txIen_q;
    logic     active_q;
    bufidx_t  actIdx_q;
    logic     rxSync1_q;
    logic     rxSync2_q;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [5:0] win;
    byteidx_t   bIdx;
    logic       setup;
    logic       wrEn;
    logic       isRx;
    logic [2:0] isTx;
    logic       isPrio;
    logic       inFrame;
    logic       mapped;
    logic [31:0] rdVal;

    assign win    = paddr[11:6];
    assign bIdx   = paddr[5:2];
    assign setup  = psel && !penable;
    assign wrEn   = psel && penable && pwrite && pready;
    assign inFrame = bIdx < byteidx_t'(FRAME_BYTES);
    assign isPrio = bIdx == `CB_LOCAL_PRIORITY_FIELD_IDX;
    assign isRx   = win == `CB_RXWIN && inFrame;
    assign isTx[0] = win == `CB_TXWIN0;
    assign isTx[1] = win == `CB_TXWIN0 + 6'h01;
    assign isTx[2] = win == `CB_TXWIN0 + 6'h02;

    function automatic logic regHit(input addr_t a, input addr_t r);
        regHit = a == r;
    endfunction : regHit

    function automatic bufidx_t txWin(input logic [2:0] h);
        txWin = h[2] ? 2'h2 : (h[1] ? 2'h1 : 2'h0);
    endfunction : txWin

    logic txHit;
    bufidx_t txB;
    assign txHit = |isTx && (inFrame || isPrio);
    assign txB   = txWin(isTx);

    assign mapped = regHit(paddr, `CB_CTRL) || regHit(paddr, `CB_RXFLAG)
                 || regHit(paddr, `CB_RXIEN) || regHit(paddr, `CB_TXFLAG)
                 || regHit(paddr, `CB_TXCTRL)
                 || regHit(paddr, `CB_ABTACK) || isRx || txHit;

    always_comb
    begin
        rdVal = 32'h0000_0000;
        if (regHit(paddr, `CB_CTRL))
            rdVal[1:0] = ctrl_q;
        else if (regHit(paddr, `CB_RXFLAG))
            rdVal[1:0] = {ovr_q, rxFull_q};
        else if (regHit(paddr, `CB_RXIEN))
            rdVal[1:0] = rxIen_q;
        else if (regHit(paddr, `CB_TXFLAG))
            rdVal[2:0] = txEmpty_q;
        else if (regHit(paddr, `CB_TXCTRL))
            rdVal[6:0] = {txIen_q, 1'b0, abtReq_q};
        else if (regHit(paddr, `CB_ABTACK))
            rdVal[2:0] = abtAck_q;
        else if (isRx)
            rdVal[7:0] = foreground_receive_buffer[bIdx];
        else if (txHit && isPrio)
            rdVal[7:0] = local_priority_field_q[txB];
        else if (txHit)
            rdVal[7:0] = txMem[txB][bIdx];
    end

    // zero-wait answer: ready in first access cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            prdata  <= (setup && !pwrite) ? rdVal : 32'h0000_0000;
            pslverr <= setup && !mapped;
        end
    end

    // ------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------
    logic     wCtrl;
    logic     wRxFlag;
    logic     wRxIen;
    logic     wTxFlag;
    logic     wTxCtrl;
    assign wCtrl   = wrEn && regHit(paddr, `CB_CTRL);
    assign wRxFlag = wrEn && regHit(paddr, `CB_RXFLAG);
    assign wRxIen  = wrEn && regHit(paddr, `CB_RXIEN);
    assign wTxFlag = wrEn && regHit(paddr, `CB_TXFLAG);
    assign wTxCtrl = wrEn && regHit(paddr, `CB_TXCTRL);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q  <= `CB_CTRL_RST;
            rxIen_q <= 2'h0;
            txIen_q <= 3'h0;
        end
        else
        begin
            if (wCtrl)
                ctrl_q <= pwdata[1:0];
            if (wRxIen)
                rxIen_q <= pwdata[1:0];
            if (wTxCtrl)
                txIen_q <= pwdata[6:4];
        end
    end

    // ------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------
    logic rxTake;
    logic frameEnd;
    logic fgFree;
    assign rxTake   = !ownFrame || ctrl_q[`CB_CTRL_LOOP];
    assign frameEnd = rxFrameOk && rxAccept && rxTake;
    // host clear of receive-full frees foreground
    assign fgFree   = wRxFlag && pwdata[`CB_RX_FULL];

    // background written while filtering, unless it holds a frame
    always_ff @(posedge core_clk)
    begin
        if (rxByteValid && !bgFull_q && rxByteIdx < byteidx_t'(FRAME_BYTES))
            background_receive_buffer[rxByteIdx] <= rxByteData;
    end

    always_ff @(posedge core_clk)
    begin
        if ((frameEnd && !rxFull_q && !bgFull_q)
            || (bgFull_q && (!rxFull_q || fgFree)))
            foreground_receive_buffer <= background_receive_buffer;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rxFull_q <= 1'b0;
            bgFull_q <= 1'b0;
            ovr_q    <= 1'b0;
        end
        else
        begin
            // pending background moves up once foreground frees
            if (bgFull_q && (!rxFull_q || fgFree))
            begin
                rxFull_q <= 1'b1;
                bgFull_q <= 1'b0;
            end
            else if (frameEnd && !rxFull_q)
                rxFull_q <= 1'b1;
            else if (frameEnd && !bgFull_q)
            begin
                bgFull_q <= 1'b1;
                if (fgFree)
                    rxFull_q <= 1'b0;
            end
            else if (fgFree)
                rxFull_q <= 1'b0;
            if (frameEnd && rxFull_q && bgFull_q)
                ovr_q <= 1'b1;
            else if (wRxFlag && pwdata[`CB_RX_OVR])
                ovr_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // transmit scheduling
    // ------------------------------------------------------------
    bufmask_t pend;
    bufidx_t  best;
    logic     anyPend;
    assign pend = ~txEmpty_q & ~abtReq_q;
    assign anyPend = |pend;

    // lowest value wins, ties to lower index
    always_comb
    begin
        best = 2'h0;
        for (int i = `CB_TX_BUFS - 1; i >= 0; i--)
        begin
            if (pend[i] && (!pend[best] || local_priority_field_q[i] <= local_priority_field_q[best]))
                best = bufidx_t'(i);
        end
    end

    logic     wTxMem;
    assign wTxMem = wrEn && txHit;

    always_ff @(posedge core_clk)
    begin
        if (wTxMem && !isPrio)
            txMem[txB][bIdx] <= pwdata[7:0];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < `CB_TX_BUFS; i++)
                local_priority_field_q[i] <= `CB_LOCAL_PRIORITY_FIELD_RST;
        end
        else if (wTxMem && isPrio)
            local_priority_field_q[txB] <= pwdata[7:0];
    end

    logic     sentNow;
    logic     endAttempt;
    assign sentNow    = active_q && txDone;
    assign endAttempt = active_q && (txDone || txError || arbLost);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            active_q <= 1'b0;
            actIdx_q <= 2'h0;
        end
        else if (endAttempt)
            active_q <= 1'b0;
        else if (arbStart && anyPend && !active_q)
        begin
            active_q <= 1'b1;
            actIdx_q <= best;
        end
    end

    // ------------------------------------------------------------
    // transmit flags
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            txEmpty_q <= `CB_TXE_RST;
            abtReq_q  <= 3'h0;
            abtAck_q  <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < `CB_TX_BUFS; i++)
            begin
                if (sentNow && actIdx_q == bufidx_t'(i))
                begin
                    txEmpty_q[i] <= 1'b1;
                    abtAck_q[i]  <= 1'b0;
                    abtReq_q[i]  <= 1'b0;
                end
                else if (abtReq_q[i] && !txEmpty_q[i]
                         && !(active_q && actIdx_q == bufidx_t'(i)))
                begin
                    txEmpty_q[i] <= 1'b1;
                    abtAck_q[i]  <= 1'b1;
                    abtReq_q[i]  <= 1'b0;
                end
                else
                begin
                    if (wTxFlag && pwdata[i] && txEmpty_q[i])
                    begin
                        txEmpty_q[i] <= 1'b0;
                        abtAck_q[i]  <= 1'b0;
                    end
                    if (wTxCtrl && pwdata[i] && !txEmpty_q[i])
                        abtReq_q[i] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pins and outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rxSync1_q        <= 1'b1;
            rxSync2_q        <= 1'b1;
            rxPinLevel       <= 1'b1;
            bus_transmit_pin <= 1'b1;
        end
        else
        begin
            rxSync1_q        <= bus_receive_pin;
            rxSync2_q        <= rxSync1_q;
            rxPinLevel       <= rxSync2_q;
            bus_transmit_pin <= engTxBit;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            txRdData  <= 8'h00;
            txValid   <= 1'b0;
            txBufSel  <= 2'h0;
            loopBack  <= 1'b0;
            clkSelOsc <= 1'b0;
            rxIrq     <= 1'b0;
            errIrq    <= 1'b0;
            txIrq     <= 1'b0;
        end
        else
        begin
            txRdData  <= (txRdIdx < byteidx_t'(FRAME_BYTES))
                         ? txMem[actIdx_q][txRdIdx] : 8'h00;
            txValid   <= active_q && !endAttempt;
            txBufSel  <= actIdx_q;
            loopBack  <= ctrl_q[`CB_CTRL_LOOP];
            clkSelOsc <= ctrl_q[`CB_CTRL_OSC];
            rxIrq     <= rxFull_q && rxIen_q[0];
            errIrq    <= ovr_q && rxIen_q[1];
            txIrq     <= |(txEmpty_q & txIen_q);
        end
    end

endmodule : can_message_buffer_manager
`default_nettype wire

// ==== bench/can_bus_node.sv ====
// far side of the bus: transceiver and other nodes as a wired-and line
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
    input  wire logic txPin,
    input  wire logic nodeDominant,
    output var  logic busLevel
);
    // any dominant node pulls the line low, idle line floats recessive
    assign busLevel = txPin & !nodeDominant;
endmodule : can_bus_node
`default_nettype wire

// ==== bench/can_buf_assertions.sv ====
// concurrent checks on the ports of the message buffer block
`timescale 1ns/1ps
`default_nettype none
`include "can_buf_map.svh"
module can_buf_assertions (
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire can_buf_pkg::addr_t     paddr,
    input wire logic [31:0]            pwdata,
    input wire logic                   bus_receive_pin,
    input wire logic                   bus_transmit_pin,
    input wire logic                   rxPinLevel,
    input wire logic                   engTxBit,
    input wire logic                   rxFrameOk,
    input wire logic                   rxAccept,
    input wire logic                   ownFrame,
    input wire logic                   arbStart,
    input wire logic                   arbLost,
    input wire logic                   txDone,
    input wire logic                   txError,
    input wire can_buf_pkg::byteidx_t  txRdIdx,
    input wire can_buf_pkg::byte_t     txRdData,
    input wire logic                   txValid,
    input wire can_buf_pkg::bufidx_t   txBufSel,
    input wire logic                   loopBack,
    input wire logic                   clkSelOsc,
    input wire logic                   rxIrq,
    input wire logic                   errIrq,
    input wire logic                   txIrq
);
    import can_buf_pkg::*;
    wire logic apbWr = psel && penable && pwrite;
    wire logic txEnd = txDone || txError || arbLost;
    wire logic ctrlWr = apbWr && paddr == `CB_CTRL;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_tx_dominant: assert property (!engTxBit |=> !bus_transmit_pin)
        else $error("transmit pin missed a dominant bit");
    a_rx_sync_delay: assert property (!$past(rst, 3) |->
        rxPinLevel == $past(bus_receive_pin, 3))
        else $error("receive level not three cycles after pin");
    a_rx_irq_cause: assert property ($rose(rxIrq) |->
        $past(rxFrameOk && rxAccept && (!ownFrame || loopBack), 2)
        || $past(apbWr, 2))
        else $error("receive interrupt without accepted frame");
    a_err_irq_cause: assert property ($rose(errIrq) |->
        $past(rxFrameOk && rxAccept, 2) || $past(apbWr, 2))
        else $error("error interrupt without accepted frame");
    a_tx_irq_cause: assert property ($rose(txIrq) |->
        $past(txDone, 2) || $past(apbWr, 2) || $past(apbWr, 3))
        else $error("transmit interrupt without release");
    a_tx_start_cause: assert property ($rose(txValid) |->
        $past(arbStart, 2))
        else $error("transmit selection without arbitration");
    a_tx_end_cause: assert property ($fell(txValid) |->
        $past(txEnd) || $past(txEnd, 2))
        else $error("active frame dropped without engine end");
    a_sel_held: assert property (txValid && !txEnd && !$past(txEnd)
        |=> $stable(txBufSel))
        else $error("selected buffer changed mid attempt");
    a_read_range: assert property (txRdIdx > 4'hC |=> txRdData == 8'h00)
        else $error("byte past the frame image not zero");
    a_osc_select: assert property (ctrlWr |=> ##1
        clkSelOsc == $past(pwdata[1], 2))
        else $error("clock source select not taken");
    a_loop_select: assert property (ctrlWr |=> ##1
        loopBack == $past(pwdata[0], 2))
        else $error("loop-back select not taken");
endmodule : can_buf_assertions

bind can_message_buffer_manager can_buf_assertions can_buf_assertions_i (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .bus_receive_pin, .bus_transmit_pin, .rxPinLevel, .engTxBit,
    .rxFrameOk, .rxAccept, .ownFrame, .arbStart, .arbLost, .txDone,
    .txError, .txRdIdx, .txRdData, .txValid, .txBufSel, .loopBack,
    .clkSelOsc, .rxIrq, .errIrq, .txIrq
);
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the message buffer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import can_buf_pkg::*;
    typedef struct {
        addr_t       a;
        logic [31:0] d;
        logic [31:0] e;
        logic        err;
    } row_t;
    logic        core_clk, rst = 1'b1, node = 1'b0, engTxBit = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    addr_t       paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat, prdata;
    logic        rxByteValid = 1'b0, rxFrameOk = 1'b0;
    logic        rxAccept = 1'b0, ownFrame = 1'b0;
    byteidx_t    rxByteIdx = 4'h0, txRdIdx = 4'h0;
    byte_t       rxByteData = 8'h00, txRdData;
    logic [3:0]  evt = 4'h0;
    logic        rerr, pready, pslverr, txPin, rxPin, rxPinLevel;
    logic        txValid, loopBack, clkSelOsc, rxIrq, errIrq, txIrq;
    bufidx_t     txBufSel;
    int          fail_count = 0, samples_checked = 0, cycles = 0;
    logic [31:0] pri[3] = '{32'h30, 32'h10, 32'h20};
    row_t rows[7] = '{
        '{12'h000, 32'hFFFFFFFF, 32'h3, 1'b0},
        '{12'h008, 32'hFFFFFFFF, 32'h3, 1'b0},
        '{12'h0B4, 32'h1FF, 32'hFF, 1'b0},
        '{12'h130, 32'h1A5, 32'hA5, 1'b0},
        '{12'h014, 32'h7, 32'h0, 1'b0},
        '{12'hFFC, 32'hFFFFFFFF, 32'h0, 1'b1},
        '{12'h000, 32'h0, 32'h0, 1'b0}
    };

    can_message_buffer_manager can_message_buffer_manager_i (
        .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .bus_receive_pin(rxPin),
        .bus_transmit_pin(txPin), .rxPinLevel, .engTxBit, .rxByteValid,
        .rxByteIdx, .rxByteData, .rxFrameOk, .rxAccept, .ownFrame,
        .arbStart(evt[0]), .txDone(evt[1]), .txError(evt[2]),
        .arbLost(evt[3]), .txRdIdx, .txRdData, .txValid, .txBufSel,
        .loopBack, .clkSelOsc, .rxIrq, .errIrq, .txIrq
    );
    can_bus_node can_bus_node_i (
        .txPin, .nodeDominant(node), .busLevel(rxPin)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        samples_checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    // one transfer, then one idle cycle with the bus released
    task automatic apb(input addr_t a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // pready ends this wait; if pready never comes, only the bench timeout ends it
        while (pready !== 1'b1)
            @(posedge core_clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic rdchk(input addr_t a, input logic [31:0] e,
                         input string m);
        apb(a, 1'b0, 32'h0);
        chk(rdat, e, m);
    endtask : rdchk

    // thirteen bytes into the background, then the end-of-frame pulse
    task automatic receive_full_flag(input byte_t b, input logic acc, input logic own);
        for (int i = 0; i < 13; i++)
        begin
            rxByteValid <= 1'b1;
            rxByteIdx <= 4'(i);
            rxByteData <= b + 8'(i);
            @(posedge core_clk);
        end
        rxByteValid <= 1'b0;
        rxFrameOk <= 1'b1;
        rxAccept <= acc;
        ownFrame <= own;
        @(posedge core_clk);
        rxFrameOk <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : receive_full_flag

    // engine pulse: 1 start, 2 done, 4 error, 8 lost
    task automatic ev(input logic [3:0] v);
        evt <= v;
        @(posedge core_clk);
        evt <= 4'h0;
        repeat (2) @(posedge core_clk);
    endtask : ev

    initial
    begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rdchk(12'h00C, 32'h7, "empty at reset");
        rdchk(12'h0B4, 32'h0, "priority at reset");
        chk(32'(txPin), 32'h1, "idle recessive");
        done("reset");
        foreach (rows[k])
        begin
            apb(rows[k].a, 1'b1, rows[k].d);
            rdchk(rows[k].a, rows[k].e, "register");
            chk(32'(rerr), 32'(rows[k].err), "slave error");
        end
        done("table");
        engTxBit <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk(32'(txPin), 32'h0, "dominant out");
        chk(32'(rxPinLevel), 32'h0, "dominant in");
        engTxBit <= 1'b1;
        node <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk(32'(txPin), 32'h1, "recessive out");
        chk(32'(rxPinLevel), 32'h0, "other node wins");
        node <= 1'b0;
        done("pins");
        apb(12'h008, 1'b1, 32'h3);
        receive_full_flag(8'h20, 1'b0, 1'b0);
        rdchk(12'h004, 32'h0, "filtered out");
        receive_full_flag(8'h30, 1'b1, 1'b1);
        rdchk(12'h004, 32'h0, "own frame held");
        chk(32'(rxIrq), 32'h0, "no rx irq");
        apb(12'h000, 1'b1, 32'h1);
        receive_full_flag(8'h40, 1'b1, 1'b1);
        rdchk(12'h004, 32'h1, "loop-back frame");
        chk(32'(rxIrq), 32'h1, "rx irq");
        for (int i = 0; i < 13; i++)
            rdchk(12'h040 + 12'(4 * i), 32'h40 + 32'(i), "fg byte");
        apb(12'h000, 1'b1, 32'h0);
        receive_full_flag(8'h50, 1'b1, 1'b0);
        receive_full_flag(8'h60, 1'b1, 1'b0);
        rdchk(12'h004, 32'h3, "overrun");
        chk(32'(errIrq), 32'h1, "overrun irq");
        rdchk(12'h040, 32'h40, "fg kept");
        done("receive");
        for (int b = 0; b < 3; b++)
        begin
            apb(12'h0B4 + 12'(64 * b), 1'b1, pri[b]);
            apb(12'h080 + 12'(64 * b), 1'b1, 32'hA0 + 32'(b));
        end
        apb(12'h010, 1'b1, 32'h70);
        apb(12'h00C, 1'b1, 32'h7);
        rdchk(12'h00C, 32'h0, "marked ready");
        ev(4'h1);
        chk(32'(txBufSel), 32'h1, "lowest local_priority_field");
        txRdIdx <= 4'h0;
        repeat (2) @(posedge core_clk);
        chk(32'(txRdData), 32'hA1, "tx byte");
        txRdIdx <= 4'hD;
        repeat (2) @(posedge core_clk);
        chk(32'(txRdData), 32'h0, "past image");
        ev(4'h4);
        ev(4'h1);
        chk(32'(txBufSel), 32'h1, "after error");
        ev(4'h2);
        rdchk(12'h00C, 32'h2, "sent empty");
        chk(32'(txIrq), 32'h1, "tx irq");
        ev(4'h1);
        ev(4'h8);
        ev(4'h1);
        chk(32'(txBufSel), 32'h2, "after lost");
        apb(12'h010, 1'b1, 32'h75);
        repeat (2) @(posedge core_clk);
        rdchk(12'h014, 32'h1, "abort granted");
        rdchk(12'h00C, 32'h3, "aborted empty");
        chk(32'(txValid), 32'h1, "active kept");
        ev(4'h2);
        rdchk(12'h014, 32'h1, "sent not aborted");
        rdchk(12'h00C, 32'h7, "all empty");
        rdchk(12'h004, 32'h3, "rx still full");
        done("transmit");
        apb(12'h004, 1'b1, 32'h1);
        rdchk(12'h004, 32'h3, "flag held");
        rdchk(12'h040, 32'h50, "moved up");
        apb(12'h004, 1'b1, 32'h3);
        rdchk(12'h004, 32'h0, "flags cleared");
        done("release");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
